// *** hw/aid_regs.vh ***
// Purpose: Constants for the identification block builder
// Assumes: Word-indexed register port, 16-bit data
// Notes:   Offsets are word indices on the register port
`ifndef AID_REGS_VH
`define AID_REGS_VH

// Register port offsets
`define AID_A_XFER      8'h00
`define AID_A_MULT      8'h01
`define AID_A_FEAT85    8'h02
`define AID_A_FEAT86    8'h03
`define AID_A_GEN_LO    8'h04
`define AID_A_GEN_HI    8'h10
`define AID_A_STATUS    8'h11
`define AID_A_STR_LO    8'h40
`define AID_A_STR_HI    8'h61

// Generic value register indices (offset minus AID_A_GEN_LO)
`define AID_G_CYL       4'h0
`define AID_G_HEADS     4'h1
`define AID_G_CUR_CYL   4'h2
`define AID_G_CUR_HEAD  4'h3
`define AID_G_CUR_SPT   4'h4
`define AID_G_CUR_CAPL  4'h5
`define AID_G_CUR_CAPH  4'h6
`define AID_G_LBA_LO    4'h7
`define AID_G_LBA_HI    4'h8
`define AID_G_ERASE     4'h9
`define AID_G_APM       4'hA
`define AID_G_AAM       4'hB
`define AID_G_SEC       4'hC
`define AID_GEN_NUM     13

// String storage
`define AID_STR_NUM     34
`define AID_STR_FW_BASE 8'h0A
`define AID_SPACE2      16'h2020

// Transfer mode codes
`define AID_XM_PIO      4'h0
`define AID_XM_MW0      4'h1
`define AID_XM_UD0      4'h4
`define AID_XM_UD5      4'h9

// Reset values
`define AID_MULT_RST    9'h010
`define AID_FEAT85_RST  16'h346B
`define AID_FEAT86_RST  16'h0000
`define AID_ERASE_RST   16'h0004
`define AID_WORD93_RST  16'h0000

// Writable masks
`define AID_FEAT85_MASK 16'h346B
`define AID_FEAT86_MASK 16'h0308
`define AID_RST_MASK    16'h1FFF

// Identify word indices
`define AID_W_SER_LO    8'd10
`define AID_W_SER_HI    8'd19
`define AID_W_FW_LO     8'd23
`define AID_W_MOD_HI    8'd46
`define AID_W_LAST      8'hFF

// Fixed identify word values
`define AID_V_W0        16'h045A
`define AID_V_W6        16'h003F
`define AID_V_W20       16'h0003
`define AID_V_W21       16'h1000
`define AID_V_W22       16'h0004
`define AID_V_W47       16'h8010
`define AID_V_W49       16'h0B00
`define AID_V_W50       16'h4000
`define AID_V_W51       16'h0200
`define AID_V_W53       16'h0007
`define AID_V_W64       16'h0003
`define AID_V_W65       16'h0078
`define AID_V_W67       16'h00F0
`define AID_V_W80       16'h003E
`define AID_V_W81       16'h0015
`define AID_V_W82       16'h346B
`define AID_V_W83       16'h4108
`define AID_V_W84       16'h4000
`define AID_V_MW_SUP    3'h7
`define AID_V_UD_SUP    6'h3F

`endif

// *** hw/aid_identify_builder.v ***
// Purpose: Builds the 256-word identification block and streams it in order
// Assumes: Register port and identify port synchronous to ref_clk
// Notes:   Strings are loaded by firmware; reset fills them with spaces
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "aid_regs.vh"

module aid_identify_builder (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire hw_reset_active,
    input wire [15:0] reset_result,
    input wire id_start,
    input wire id_rd,
    output reg [15:0] id_data,
    output reg id_valid,
    output reg id_busy,
    output reg id_done
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding functions

    // Selected bits {ultra[5:0], multiword[2:0]}; one-hot or all clear
    function [8:0] mode_sel;
        input [3:0] code;
        begin
            mode_sel = 9'h000;
            if (code >= `AID_XM_UD0 && code <= `AID_XM_UD5) begin
                mode_sel[3 + code - `AID_XM_UD0] = 1'b1;
            end else if (code >= `AID_XM_MW0 && code < `AID_XM_UD0) begin
                mode_sel[code - `AID_XM_MW0] = 1'b1;
            end
        end
    endfunction

    function mode_ok;
        input [3:0] code;
        begin
            mode_ok = (code <= `AID_XM_UD5);
        end
    endfunction

    // Power-of-two block sizes 2..16 only
    function mult_ok;
        input [7:0] cnt;
        begin
            mult_ok = (cnt == 8'h02) || (cnt == 8'h04) || (cnt == 8'h08) || (cnt == 8'h10);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Settings registers

    reg [3:0] xfer_reg;
    reg [8:0] mult_reg;
    reg [15:0] feat85_reg;
    reg [15:0] feat86_reg;
    reg [15:0] word93_reg;
    reg reject_reg;
    reg [7:0] word_idx_reg;
    reg [15:0] gen_reg [0:`AID_GEN_NUM-1];
    reg [15:0] str_reg [0:`AID_STR_NUM-1];

    wire in_gen = (reg_addr >= `AID_A_GEN_LO) && (reg_addr <= `AID_A_GEN_HI);
    wire in_str = (reg_addr >= `AID_A_STR_LO) && (reg_addr <= `AID_A_STR_HI);
    wire [7:0] gen_off = reg_addr - `AID_A_GEN_LO;
    wire [3:0] gen_idx = gen_off[3:0];
    wire [7:0] str_idx = reg_addr - `AID_A_STR_LO;

    always @(posedge ref_clk) begin
        if (rst) begin
            xfer_reg <= `AID_XM_PIO;
            mult_reg <= `AID_MULT_RST;
            feat85_reg <= `AID_FEAT85_RST;
            feat86_reg <= `AID_FEAT86_RST;
            reject_reg <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `AID_A_XFER) begin
                // Unknown codes leave the mode in force untouched
                if (mode_ok(reg_wdata[3:0])) begin
                    xfer_reg <= reg_wdata[3:0];
                end
                reject_reg <= ~mode_ok(reg_wdata[3:0]);
            end else if (reg_addr == `AID_A_MULT) begin
                if (mult_ok(reg_wdata[7:0])) begin
                    mult_reg <= reg_wdata[8:0];
                end else begin
                    mult_reg[8] <= reg_wdata[8];
                end
                reject_reg <= ~mult_ok(reg_wdata[7:0]);
            end else if (reg_addr == `AID_A_FEAT85) begin
                feat85_reg <= reg_wdata & `AID_FEAT85_MASK;
            end else if (reg_addr == `AID_A_FEAT86) begin
                feat86_reg <= reg_wdata & `AID_FEAT86_MASK;
            end
        end
    end

    // Result bits are frozen outside hardware reset; upper cable bits follow live
    always @(posedge ref_clk) begin
        if (rst) begin
            word93_reg <= `AID_WORD93_RST;
        end else begin
            word93_reg[15:13] <= reset_result[15:13];
            if (hw_reset_active) begin
                word93_reg[12:0] <= reset_result[12:0];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `AID_GEN_NUM; gi = gi + 1) begin : g_gen
            always @(posedge ref_clk) begin
                if (rst) begin
                    gen_reg[gi] <= (gi == `AID_G_ERASE) ? `AID_ERASE_RST : 16'h0000;
                end else if (reg_wr && in_gen && gen_idx == gi) begin
                    gen_reg[gi] <= reg_wdata;
                end
            end
        end
        for (gi = 0; gi < `AID_STR_NUM; gi = gi + 1) begin : g_str
            always @(posedge ref_clk) begin
                if (rst) begin
                    str_reg[gi] <= `AID_SPACE2;
                end else if (reg_wr && in_str && str_idx == gi) begin
                    str_reg[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register read port, data one cycle after the strobe

    wire [15:0] status_val = {5'h00, id_done, id_busy, reject_reg, word_idx_reg};
    reg [15:0] rdata_next;

    // Idle cycles read zero so a stale value is never taken for data
    always @* begin
        rdata_next = 16'h0000;
        if (!reg_rd) begin
            rdata_next = 16'h0000;
        end else if (reg_addr == `AID_A_XFER) begin
            rdata_next = {12'h000, xfer_reg};
        end else if (reg_addr == `AID_A_MULT) begin
            rdata_next = {7'h00, mult_reg};
        end else if (reg_addr == `AID_A_FEAT85) begin
            rdata_next = feat85_reg;
        end else if (reg_addr == `AID_A_FEAT86) begin
            rdata_next = feat86_reg;
        end else if (in_gen) begin
            rdata_next = gen_reg[gen_idx];
        end else if (reg_addr == `AID_A_STATUS) begin
            rdata_next = status_val;
        end else if (in_str) begin
            rdata_next = str_reg[str_idx[5:0]];
        end else begin
            rdata_next = 16'h0000;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Identify word assembly

    reg [15:0] word_val;
    wire [8:0] sel = mode_sel(xfer_reg);
    wire [7:0] s_ser = word_idx_reg - `AID_W_SER_LO;
    wire [7:0] s_fw = word_idx_reg - `AID_W_FW_LO + `AID_STR_FW_BASE;

    // Live words follow the settings in force when the word is fetched
    wire [15:0] live_w59 = {7'h00, mult_reg};
    wire [15:0] live_w63 = {5'h00, sel[2:0], 5'h00, `AID_V_MW_SUP};
    wire [15:0] live_w85 = feat85_reg & `AID_FEAT85_MASK;
    wire [15:0] live_w86 = feat86_reg & `AID_FEAT86_MASK;
    wire [15:0] live_w88 = {2'b00, sel[8:3], 2'b00, `AID_V_UD_SUP};
    wire [15:0] live_w91 = {8'h00, gen_reg[`AID_G_APM][7:0]};
    wire [15:0] live_w94 = {8'h00, gen_reg[`AID_G_AAM][7:0]};

    always @* begin
        word_val = 16'h0000;
        if (word_idx_reg >= `AID_W_SER_LO && word_idx_reg <= `AID_W_SER_HI) begin
            word_val = str_reg[s_ser[5:0]];
        end else if (word_idx_reg >= `AID_W_FW_LO && word_idx_reg <= `AID_W_MOD_HI) begin
            word_val = str_reg[s_fw[5:0]];
        end else begin
            case (word_idx_reg)
                8'd0: word_val = `AID_V_W0;
                8'd1: word_val = gen_reg[`AID_G_CYL];
                8'd3: word_val = gen_reg[`AID_G_HEADS];
                8'd6: word_val = `AID_V_W6;
                8'd20: word_val = `AID_V_W20;
                8'd21: word_val = `AID_V_W21;
                8'd22: word_val = `AID_V_W22;
                8'd47: word_val = `AID_V_W47;
                8'd49: word_val = `AID_V_W49;
                8'd50: word_val = `AID_V_W50;
                8'd51: word_val = `AID_V_W51;
                8'd52: word_val = `AID_V_W51;
                8'd53: word_val = `AID_V_W53;
                8'd54: word_val = gen_reg[`AID_G_CUR_CYL];
                8'd55: word_val = gen_reg[`AID_G_CUR_HEAD];
                8'd56: word_val = gen_reg[`AID_G_CUR_SPT];
                8'd57: word_val = gen_reg[`AID_G_CUR_CAPL];
                8'd58: word_val = gen_reg[`AID_G_CUR_CAPH];
                8'd59: word_val = live_w59;
                8'd60: word_val = gen_reg[`AID_G_LBA_LO];
                8'd61: word_val = gen_reg[`AID_G_LBA_HI];
                8'd63: word_val = live_w63;
                8'd64: word_val = `AID_V_W64;
                8'd65: word_val = `AID_V_W65;
                8'd66: word_val = `AID_V_W65;
                8'd67: word_val = `AID_V_W67;
                8'd68: word_val = `AID_V_W65;
                8'd80: word_val = `AID_V_W80;
                8'd81: word_val = `AID_V_W81;
                8'd82: word_val = `AID_V_W82;
                8'd83: word_val = `AID_V_W83;
                8'd84: word_val = `AID_V_W84;
                8'd85: word_val = live_w85;
                8'd86: word_val = live_w86;
                8'd87: word_val = `AID_V_W84;
                8'd88: word_val = live_w88;
                8'd89: word_val = gen_reg[`AID_G_ERASE];
                8'd91: word_val = live_w91;
                8'd93: word_val = word93_reg;
                8'd94: word_val = live_w94;
                8'd128: word_val = gen_reg[`AID_G_SEC];
                default: word_val = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Identify stream, one word per read strobe, ascending

    reg [7:0] word_idx_next;
    reg busy_next;
    reg done_next;
    wire take_word = id_rd && id_busy && !id_start;
    wire last_word = (word_idx_reg == `AID_W_LAST);

    always @* begin
        word_idx_next = word_idx_reg;
        busy_next = id_busy;
        done_next = id_done;
        if (id_start) begin
            // Restart wins over a read in the same cycle
            word_idx_next = 8'h00;
            busy_next = 1'b1;
            done_next = 1'b0;
        end else if (take_word) begin
            word_idx_next = word_idx_reg + 8'h01;
            if (last_word) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    // Data holds between words so a slow host may sample late
    always @(posedge ref_clk) begin
        if (rst) begin
            word_idx_reg <= 8'h00;
            id_busy <= 1'b0;
            id_done <= 1'b0;
            id_valid <= 1'b0;
            id_data <= 16'h0000;
        end else begin
            word_idx_reg <= word_idx_next;
            id_busy <= busy_next;
            id_done <= done_next;
            id_valid <= take_word;
            if (take_word) begin
                id_data <= word_val;
            end
        end
    end

endmodule // aid_identify_builder

// *** dv/aid_chk_assertions.sv ***
// Purpose: Port-level checks for the identify block builder
// Assumes: One clock, rst synchronous active high
// Notes:   widx_reg rebuilds the word index from the handshake
`timescale 1ns/100ps
`include "aid_regs.vh"
module aid_chk (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire hw_reset_active,
    input wire [15:0] reset_result,
    input wire id_start,
    input wire id_rd,
    input wire [15:0] id_data,
    input wire id_valid,
    input wire id_busy,
    input wire id_done
);
    reg [8:0] widx_reg;
    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (rst || id_start) begin
            widx_reg <= 9'h000;
        end else if (id_valid) begin
            widx_reg <= widx_reg + 9'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_valid_follows: assert property (id_rd && id_busy && !id_start |=> id_valid)
        else $error("word not returned after request");
    chk_valid_cause: assert property (id_valid |-> $past(id_rd) && $past(id_busy))
        else $error("word returned without request");
    chk_start_busy: assert property (id_start |=> id_busy [*8])
        else $error("stream not busy after start");
    chk_done_idle: assert property (id_done |-> !id_busy)
        else $error("done while busy");
    chk_data_hold: assert property (!id_valid && !$past(id_start) |-> $stable(id_data))
        else $error("word changed without request");
    chk_word_zero: assert property (id_valid && widx_reg == 9'h000 |-> id_data == `AID_V_W0)
        else $error("configuration word wrong");
    chk_valid_word: assert property (id_valid && widx_reg == 9'h035 |-> id_data == 16'h0007)
        else $error("validity word wrong");
    chk_mw_select: assert property (id_valid && widx_reg == 9'h03F |-> id_data[15:11] == 5'h00
        && id_data[7:0] == 8'h07 && $countones(id_data[10:8]) <= 1) else $error("dma word wrong");
    chk_ud_select: assert property (id_valid && widx_reg == 9'h058 |-> id_data[15:14] == 2'h0
        && id_data[7:0] == 8'h3F && $countones(id_data[13:8]) <= 1) else $error("ultra word wrong");
endmodule // aid_chk

// *** dv/aid_host_model.sv ***
// Purpose: Host side that fetches the identification block
// Assumes: Words arrive one cycle after each read request
// Notes:   gap sets idle cycles between reads to act slow
`timescale 1ns/100ps
module aid_host_model (
    input wire ref_clk,
    input wire [15:0] id_data,
    input wire id_valid,
    output reg id_start,
    output reg id_rd
);
    reg [15:0] blk [0:255];
    reg [8:0] cnt;
    initial begin
        id_start = 1'b0;
        id_rd = 1'b0;
        cnt = 9'h000;
    end
    always @(posedge ref_clk) begin
        if (id_start) begin
            cnt <= 9'h000;
        end else if (id_valid) begin
            blk[cnt[7:0]] <= id_data;
            cnt <= cnt + 9'h001;
        end
    end
    task read_block(input integer gap);
        integer i;
        begin
            @(posedge ref_clk);
            id_start <= 1'b1;
            @(posedge ref_clk);
            id_start <= 1'b0;
            for (i = 0; i < 256; i = i + 1) begin
                id_rd <= 1'b1;
                @(posedge ref_clk);
                if (gap > 0) begin
                    id_rd <= 1'b0;
                    repeat (gap) @(posedge ref_clk);
                end
            end
            id_rd <= 1'b0;
            // Last capture lands one edge later
            repeat (2) @(posedge ref_clk);
        end
    endtask
endmodule // aid_host_model

// *** dv/tb_aid_identify_builder.sv ***
// Purpose: Self-checking bench for the identify block builder
// Assumes: Host model drives the identify port
// Notes:   Expected words come from the field layouts
`timescale 1ns/100ps
`include "aid_regs.vh"
module tb_aid_identify_builder;
    reg ref_clk, rst, reg_wr, reg_rd, hw_reset_active;
    reg [7:0] reg_addr;
    reg [15:0] reg_wdata, reset_result, rd_val;
    wire [15:0] reg_rdata, id_data;
    wire id_start, id_rd, id_valid, id_busy, id_done;
    integer num_errors, cmp_count, i;
    aid_identify_builder i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_reset_active(hw_reset_active),
        .reset_result(reset_result), .id_start(id_start), .id_rd(id_rd), .id_data(id_data),
        .id_valid(id_valid), .id_busy(id_busy), .id_done(id_done));
    aid_host_model i_host (.ref_clk(ref_clk), .id_data(id_data), .id_valid(id_valid),
        .id_start(id_start), .id_rd(id_rd));
    ////////////////////////////////////////////////////////////////////////
    task check(input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task drive_result(input act, input [15:0] v);
        begin
            hw_reset_active <= act;
            reset_result <= v;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            #1;
            rd_val = reg_rdata;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task test_defaults;
        integer wi [0:13];
        reg [15:0] ev [0:13];
        begin
            wi = '{0, 2, 10, 46, 49, 51, 59, 64, 80, 82, 83, 85, 89, 255};
            ev = '{16'h045A, 16'h0000, 16'h2020, 16'h2020, 16'h0B00, 16'h0200, 16'h0010,
                16'h0003, 16'h003E, 16'h346B, 16'h4108, 16'h346B, 16'h0004, 16'h0000};
            i_host.read_block(0);
            for (i = 0; i < 14; i = i + 1) begin
                check(i_host.blk[wi[i]], ev[i]);
            end
            rd(`AID_A_STATUS);
            check({14'h0000, rd_val[10:9]}, 16'h0002);
            wr(8'h20, 16'hFFFF);
            rd(8'h20);
            check(rd_val, 16'h0000);
        end
    endtask
    task test_modes;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                wr(`AID_A_XFER, i[15:0]);
                i_host.read_block(i % 3);
                check(i_host.blk[63], 16'h0007 | ((i >= 1 && i <= 3) ? (16'h0080 << i) : 16'h0000));
                check(i_host.blk[88], 16'h003F | ((i >= 4) ? (16'h0100 << (i - 4)) : 16'h0000));
            end
            wr(`AID_A_XFER, 16'h000A);
            rd(`AID_A_STATUS);
            check({15'h0000, rd_val[8]}, 16'h0001);
            i_host.read_block(0);
            check(i_host.blk[88], 16'h203F);
        end
    endtask
    task test_mult;
        begin
            for (i = 1; i < 5; i = i + 1) begin
                wr(`AID_A_MULT, 16'h0100 | (16'h0001 << i));
                i_host.read_block(0);
                check(i_host.blk[59], 16'h0100 | (16'h0001 << i));
            end
            wr(`AID_A_MULT, 16'h0003);
            i_host.read_block(0);
            check(i_host.blk[59], 16'h0010);
        end
    endtask
    task test_features;
        begin
            wr(`AID_A_FEAT85, 16'hFFFF);
            wr(`AID_A_FEAT86, 16'hFFFF);
            wr(8'h0D, 16'h0008);
            wr(8'h40, 16'h3132);
            wr(8'h4A, 16'h4142);
            wr(8'h61, 16'h4320);
            drive_result(1'b0, 16'hFFFF);
            i_host.read_block(1);
            check(i_host.blk[85], 16'h346B);
            check(i_host.blk[86], 16'h0308);
            check(i_host.blk[89], 16'h0008);
            check(i_host.blk[10], 16'h3132);
            check(i_host.blk[23], 16'h4142);
            check(i_host.blk[46], 16'h4320);
            check(i_host.blk[93], 16'hE000);
            drive_result(1'b1, 16'hFFFF);
            @(posedge ref_clk);
            drive_result(1'b0, 16'h0000);
            wr(`AID_A_FEAT85, 16'h0000);
            wr(`AID_A_FEAT86, 16'h0000);
            i_host.read_block(0);
            check(i_host.blk[93], 16'h1FFF);
            check(i_host.blk[85], 16'h0000);
            check(i_host.blk[86], 16'h0000);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
        begin
            $display("errors %0d compares %0d", num_errors, cmp_count);
            if (num_errors == 0 && cmp_count > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        {rst, reg_wr, reg_rd, hw_reset_active} = 4'hF & 4'h8;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reset_result = 16'h0000;
        num_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        test_defaults;
        test_modes;
        test_mult;
        test_features;
        give_verdict;
    end
    // About six and a half times the expected run
    initial begin
        #200000;
        num_errors = num_errors + 1;
        give_verdict;
    end
endmodule // tb_aid_identify_builder
bind aid_identify_builder aid_chk i_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_reset_active(hw_reset_active),
    .reset_result(reset_result), .id_start(id_start), .id_rd(id_rd), .id_data(id_data),
    .id_valid(id_valid), .id_busy(id_busy), .id_done(id_done));
